// *** rtl/msc_stat_counters.sv ***
// Design decision made here: the address-and-strobe port.
module msc_stat_counters (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Transmit frame status
  input wire logic i_tx_done,
  input wire logic i_tx_underrun,
  input wire logic [4:0] i_tx_coll_cnt,
  input wire logic i_tx_late_coll,
  input wire logic i_tx_deferred,
  input wire logic i_tx_crs_seen,
  input wire logic i_tx_crs_dropped,
  // Receive frame status
  input wire logic i_rx_done,
  input wire logic [10:0] i_rx_len,
  input wire logic i_rx_odd_bits,
  input wire logic i_rx_crc_bad,
  input wire logic i_rx_sym_err,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_copied,
  input wire logic i_rx_pause
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [31:0] net_control_reg;
  logic [31:0] net_config_reg;
  logic ctl_hit;
  logic cfg_hit;
  logic rx_enable;
  logic stat_write_en;
  logic full_duplex;
  logic big_frames;

  assign ctl_hit = i_addr == msc_pkg::NET_CONTROL_ADDR;
  assign cfg_hit = i_addr == msc_pkg::NET_CONFIG_ADDR;
  assign rx_enable = net_control_reg[msc_pkg::RX_EN_BIT];
  assign stat_write_en = net_control_reg[msc_pkg::STAT_WE_BIT];
  assign full_duplex = net_config_reg[msc_pkg::FULL_DUPLEX_BIT];
  assign big_frames = net_config_reg[msc_pkg::BIG_FRAME_BIT];

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      net_control_reg <= msc_pkg::NET_CONTROL_RST;
    end else if (i_clk_en && i_wr && ctl_hit) begin
      net_control_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      net_config_reg <= msc_pkg::NET_CONFIG_RST;
    end else if (i_clk_en && i_wr && cfg_hit) begin
      net_config_reg <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive classification
  logic [10:0] max_len;
  logic len_ok;
  logic rx_bad;
  logic rx_good;
  logic rx_event;
  logic pause_tally;
  logic good_frame_tally;
  logic crc_fail_tally;
  logic align_fail_tally;

  assign max_len = big_frames ? msc_pkg::MAX_BIG_FRAME_LEN : msc_pkg::MAX_FRAME_LEN;
  assign len_ok = (i_rx_len >= msc_pkg::MIN_FRAME_LEN) && (i_rx_len <= max_len);
  // Alignment errors also carry a bad CRC, so one term covers both
  assign rx_bad = i_rx_crc_bad || i_rx_sym_err;
  assign rx_good = len_ok && !rx_bad;
  // Status pulse arrives once per frame from the receiver
  assign rx_event = i_rx_done && rx_enable;
  assign pause_tally = rx_event && rx_good && i_rx_pause;
  assign good_frame_tally = rx_event && rx_good && i_rx_addr_match && i_rx_copied;
  assign crc_fail_tally = rx_event && len_ok && !i_rx_odd_bits && rx_bad;
  assign align_fail_tally = rx_event && len_ok && i_rx_odd_bits && rx_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit classification
  logic tx_event;
  logic tx_starved_tally;
  logic retry_exhausted;
  logic no_coll;
  logic tx_good_tally;
  logic one_collision_tally;
  logic several_collision_tally;
  logic deferral_tally;
  logic late_hit_tally;
  logic too_many_hits_tally;
  logic carrier_loss_tally;

  // Underrun frames are filtered here so no other counter sees them
  assign tx_event = i_tx_done && !i_tx_underrun;
  assign tx_starved_tally = i_tx_done && i_tx_underrun;
  assign retry_exhausted = i_tx_coll_cnt == msc_pkg::EXCESS_COLL;
  assign no_coll = i_tx_coll_cnt == '0;
  assign tx_good_tally = tx_event && !retry_exhausted;
  assign one_collision_tally = tx_good_tally && (i_tx_coll_cnt == 5'h01);
  assign several_collision_tally = tx_good_tally && (i_tx_coll_cnt >= 5'h02)
      && (i_tx_coll_cnt <= msc_pkg::MULTI_COLL_MAX);
  assign deferral_tally = tx_event && i_tx_deferred && no_coll && !i_tx_late_coll;
  // Late collision also sits in the collision count, counting it twice
  assign late_hit_tally = tx_event && i_tx_late_coll;
  assign too_many_hits_tally = tx_event && retry_exhausted;
  // Carrier error feeds nothing else; other terms ignore crs inputs
  assign carrier_loss_tally = tx_event && !full_duplex && no_coll
      && (!i_tx_crs_seen || i_tx_crs_dropped);

  ////////////////////////////////////////////////////////////////////////////
  // Counter bank
  msc_pkg::msc_cnt_vec_t inc_vec;
  msc_pkg::msc_cnt_vec_t rd_hit;
  msc_pkg::msc_cnt_vec_t wr_hit;
  logic [31:0] cnt_val [msc_pkg::NUM_CNT];

  assign inc_vec = {carrier_loss_tally, tx_starved_tally, too_many_hits_tally,
                    late_hit_tally, deferral_tally, align_fail_tally, crc_fail_tally,
                    good_frame_tally, several_collision_tally, one_collision_tally,
                    tx_good_tally, pause_tally} & {msc_pkg::NUM_CNT{i_clk_en}};

  for (genvar k = 0; k < msc_pkg::NUM_CNT; k++) begin : g_cnt
    msc_cnt_if cif ();
    assign rd_hit[k] = i_clk_en && i_rd && (i_addr == msc_pkg::CNT_ADDR[k]);
    // Writes without the enable bit fall on the floor
    assign wr_hit[k] = i_clk_en && i_wr && stat_write_en
        && (i_addr == msc_pkg::CNT_ADDR[k]);
    assign cif.inc = inc_vec[k];
    assign cif.clr = rd_hit[k];
    assign cif.wr = wr_hit[k];
    assign cif.wdata = i_wdata;
    assign cnt_val[k] = cif.value;

    msc_sat_counter #(
      .W(msc_pkg::CNT_W[k])
    ) u_cnt (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_clk_en(i_clk_en),
      .cnt(cif.counter)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [31:0] read_sel;
  logic [31:0] next_rdata;

  always_comb begin
    read_sel = '0;
    for (int k = 0; k < msc_pkg::NUM_CNT; k++) begin
      if (i_addr == msc_pkg::CNT_ADDR[k]) begin
        read_sel = cnt_val[k];
      end
    end
    if (ctl_hit) begin
      read_sel = net_control_reg;
    end
    if (cfg_hit) begin
      read_sel = net_config_reg;
    end
  end

  // Data stands for exactly one cycle; unmapped reads give zero
  assign next_rdata = i_rd ? read_sel : '0;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_underrun_alone: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_tx_done && i_tx_underrun && !i_rx_done)
      |-> inc_vec == msc_pkg::UNDERRUN_ONLY)
    else $error("underrun frame bumped another counter");

  a_rx_gated: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !rx_enable |-> (inc_vec & msc_pkg::RX_CNT_MASK) == '0)
    else $error("receive counter moved while receive disabled");

  a_good_length: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (inc_vec[msc_pkg::IDX_PAUSE] || inc_vec[msc_pkg::IDX_RX_OK])
      |-> i_rx_len >= 11'h040 && i_rx_len <= (big_frames ? 11'h600 : 11'h5ee)
          && !i_rx_crc_bad && !i_rx_sym_err)
    else $error("good frame counted outside length or with error");

  a_late_twice: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && tx_event && i_tx_late_coll && i_tx_coll_cnt >= 5'h01
      && i_tx_coll_cnt <= msc_pkg::MULTI_COLL_MAX)
      |-> inc_vec[msc_pkg::IDX_LATE]
          && (inc_vec[msc_pkg::IDX_SINGLE] || inc_vec[msc_pkg::IDX_MULTI]))
    else $error("late collision not counted twice");

  a_carrier_half: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    full_duplex |-> !inc_vec[msc_pkg::IDX_CARRIER])
    else $error("carrier error counted in full duplex");

  a_read_clears: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (rd_hit[msc_pkg::IDX_TX_OK] && !inc_vec[msc_pkg::IDX_TX_OK])
      |=> cnt_val[msc_pkg::IDX_TX_OK] == 32'h0 && o_rdata == $past(cnt_val[msc_pkg::IDX_TX_OK]))
    else $error("read did not return and clear counter");

  a_counter_sticks: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (cnt_val[msc_pkg::IDX_CRC] == 32'h0000_00ff && !rd_hit[msc_pkg::IDX_CRC]
      && !wr_hit[msc_pkg::IDX_CRC])
      |=> cnt_val[msc_pkg::IDX_CRC] == 32'h0000_00ff)
    else $error("saturated counter changed");

  a_write_locked: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_wr && !stat_write_en && i_addr == msc_pkg::CRC_ERROR_ADDR
      && !inc_vec[msc_pkg::IDX_CRC])
      |=> $stable(cnt_val[msc_pkg::IDX_CRC]))
    else $error("locked write altered a counter");

  a_rdata_window: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && !i_rd) |=> o_rdata == 32'h0)
    else $error("read data outside its cycle");

  a_single_count: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_SINGLE] |-> !inc_vec[msc_pkg::IDX_MULTI] && i_tx_coll_cnt == 5'h01)
    else $error("single and multi collision mixed");

  a_pause_moves: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (inc_vec[msc_pkg::IDX_PAUSE] && !rd_hit[msc_pkg::IDX_PAUSE] && !wr_hit[msc_pkg::IDX_PAUSE]
      && cnt_val[msc_pkg::IDX_PAUSE] < 32'h0000_ffff)
      |=> cnt_val[msc_pkg::IDX_PAUSE] == $past(cnt_val[msc_pkg::IDX_PAUSE]) + 32'h1)
    else $error("pause counter did not step by one");

  a_excess_only: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_tx_done && !i_tx_underrun && i_tx_coll_cnt == 5'h10)
      |-> inc_vec[msc_pkg::IDX_EXCESS] && !inc_vec[msc_pkg::IDX_TX_OK]
          && !inc_vec[msc_pkg::IDX_SINGLE] && !inc_vec[msc_pkg::IDX_MULTI])
    else $error("abandoned frame counted as sent");

  a_multi_range: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_MULTI]
      |-> !i_tx_underrun && i_tx_coll_cnt >= 5'h02 && i_tx_coll_cnt <= 5'h0f)
    else $error("multi collision count outside two to fifteen");

  a_tx_ok_cause: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_TX_OK]
      |-> i_tx_done && !i_tx_underrun && i_tx_coll_cnt != 5'h10)
    else $error("sent frame counted without success");

  a_defer_counted: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_tx_done && !i_tx_underrun && i_tx_deferred && i_tx_coll_cnt == 5'h00)
      |-> inc_vec[msc_pkg::IDX_DEFER])
    else $error("deferred frame not counted");

  a_defer_clean: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_DEFER]
      |-> i_tx_deferred && !i_tx_underrun && i_tx_coll_cnt == 5'h00 && !i_tx_late_coll)
    else $error("deferral counted with collision or underrun");

  a_carrier_clean: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_CARRIER]
      |-> !i_tx_underrun && i_tx_coll_cnt == 5'h00 && (!i_tx_crs_seen || i_tx_crs_dropped))
    else $error("carrier error counted without cause");

  a_carrier_neutral: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_CARRIER] |-> inc_vec[msc_pkg::IDX_TX_OK])
    else $error("carrier error blocked the sent count");

  a_crc_whole: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_CRC]
      |-> !i_rx_odd_bits && (i_rx_crc_bad || i_rx_sym_err) && i_rx_len >= 11'h040)
    else $error("crc error counted for wrong frame");

  a_align_odd: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_ALIGN]
      |-> i_rx_odd_bits && (i_rx_crc_bad || i_rx_sym_err) && i_rx_len >= 11'h040)
    else $error("alignment error counted for wrong frame");

  a_rx_ok_copied: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_RX_OK] |-> i_rx_addr_match && i_rx_copied && rx_enable)
    else $error("received frame counted without match or copy");

  a_late_cause: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    inc_vec[msc_pkg::IDX_LATE] |-> i_tx_late_coll && !i_tx_underrun)
    else $error("late collision counted without cause");

  a_idle_quiet: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (!i_tx_done && !i_rx_done) |-> inc_vec == '0)
    else $error("counter moved without a frame");

  a_write_lands: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_clk_en && i_wr && stat_write_en && i_addr == msc_pkg::CRC_ERROR_ADDR)
      |=> cnt_val[msc_pkg::IDX_CRC] == {24'h0, $past(i_wdata[7:0])})
    else $error("enabled write did not load the counter");

endmodule : msc_stat_counters

// *** rtl/msc_pkg.sv ***
package msc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int NUM_CNT = 12;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int LEN_W = 11;
  localparam int COLL_W = 5;

  localparam logic [31:0] NET_CONTROL_ADDR = 32'hf802c000;
  localparam logic [31:0] NET_CONFIG_ADDR = 32'hf802c004;
  localparam logic [31:0] PAUSE_RX_OK_ADDR = 32'hf802c03c;
  localparam logic [31:0] TX_OK_ADDR = 32'hf802c040;
  localparam logic [31:0] SINGLE_COLLISION_ADDR = 32'hf802c044;
  localparam logic [31:0] MULTI_COLLISION_ADDR = 32'hf802c048;
  localparam logic [31:0] RX_OK_ADDR = 32'hf802c04c;
  localparam logic [31:0] CRC_ERROR_ADDR = 32'hf802c050;
  localparam logic [31:0] ALIGNMENT_ERROR_ADDR = 32'hf802c054;
  localparam logic [31:0] DEFERRED_TX_ADDR = 32'hf802c058;
  localparam logic [31:0] LATE_COLLISION_ADDR = 32'hf802c05c;
  localparam logic [31:0] EXCESSIVE_COLLISION_ADDR = 32'hf802c060;
  localparam logic [31:0] TX_UNDERRUN_ADDR = 32'hf802c064;
  localparam logic [31:0] CARRIER_SENSE_ERROR_ADDR = 32'hf802c068;

  // Counter indices, in address order
  localparam int IDX_PAUSE = 0;
  localparam int IDX_TX_OK = 1;
  localparam int IDX_SINGLE = 2;
  localparam int IDX_MULTI = 3;
  localparam int IDX_RX_OK = 4;
  localparam int IDX_CRC = 5;
  localparam int IDX_ALIGN = 6;
  localparam int IDX_DEFER = 7;
  localparam int IDX_LATE = 8;
  localparam int IDX_EXCESS = 9;
  localparam int IDX_UNDERRUN = 10;
  localparam int IDX_CARRIER = 11;

  localparam logic [31:0] CNT_ADDR [NUM_CNT] = '{
    PAUSE_RX_OK_ADDR, TX_OK_ADDR, SINGLE_COLLISION_ADDR, MULTI_COLLISION_ADDR,
    RX_OK_ADDR, CRC_ERROR_ADDR, ALIGNMENT_ERROR_ADDR, DEFERRED_TX_ADDR,
    LATE_COLLISION_ADDR, EXCESSIVE_COLLISION_ADDR, TX_UNDERRUN_ADDR,
    CARRIER_SENSE_ERROR_ADDR};
  localparam int unsigned CNT_W [NUM_CNT] = '{16, 24, 16, 16, 24, 8, 8, 16, 8, 8, 8, 8};

  localparam logic [NUM_CNT-1:0] RX_CNT_MASK = 12'h071;
  localparam logic [NUM_CNT-1:0] UNDERRUN_ONLY = 12'h400;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields and reset values
  localparam int RX_EN_BIT = 2;
  localparam int STAT_WE_BIT = 7;
  localparam int FULL_DUPLEX_BIT = 1;
  localparam int BIG_FRAME_BIT = 8;
  localparam logic [31:0] NET_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] NET_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Frame limits
  localparam logic [LEN_W-1:0] MIN_FRAME_LEN = 11'h040;
  localparam logic [LEN_W-1:0] MAX_FRAME_LEN = 11'h5ee;
  localparam logic [LEN_W-1:0] MAX_BIG_FRAME_LEN = 11'h600;
  localparam logic [COLL_W-1:0] EXCESS_COLL = 5'h10;
  localparam logic [COLL_W-1:0] MULTI_COLL_MAX = 5'h0f;

  typedef logic [NUM_CNT-1:0] msc_cnt_vec_t;

endpackage : msc_pkg

// *** rtl/msc_cnt_if.sv ***
interface msc_cnt_if;
  logic inc;
  logic clr;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] value;

  modport counter (input inc, input clr, input wr, input wdata, output value);
  modport owner (output inc, output clr, output wr, output wdata, input value);
endinterface : msc_cnt_if

// *** rtl/msc_sat_counter.sv ***
module msc_sat_counter #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Counter controls
  msc_cnt_if.counter cnt
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic at_max;
  logic [W-1:0] count_up;

  assign at_max = &count;
  // Sticks at all ones instead of wrapping
  assign count_up = at_max ? count : count + W'(1);

  // Event in the read cycle survives as a count of one
  always_comb begin
    next_count = count;
    if (cnt.wr) begin
      next_count = cnt.wdata[W-1:0];
    end else if (cnt.clr) begin
      next_count = cnt.inc ? W'(1) : '0;
    end else if (cnt.inc) begin
      next_count = count_up;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= msc_pkg::CNT_RST[W-1:0];
    end else if (i_clk_en) begin
      count <= next_count;
    end
  end

  if (W < 32) begin : g_pad
    assign cnt.value = {{(32 - W){1'b0}}, count};
  end else begin : g_full
    assign cnt.value = count[31:0];
  end

endmodule : msc_sat_counter

// *** bench/msc_frame_src.sv ***
module msc_frame_src (
  // Clock
  input wire logic i_ref_clk,
  // Frame status toward the counters
  output logic o_tx_done,
  output logic [9:0] o_tx_stat,
  output logic o_rx_done,
  output logic [16:0] o_rx_stat
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_tx_done = 1'b0;
    o_tx_stat = 10'h000;
    o_rx_done = 1'b0;
    o_rx_stat = 17'h00000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One done pulse per frame; status flips between frames so stale values
  // never pass for valid ones
  task send_tx(input logic [9:0] s);
    @(posedge i_ref_clk);
    o_tx_done <= 1'b1;
    o_tx_stat <= s;
    @(posedge i_ref_clk);
    o_tx_done <= 1'b0;
    o_tx_stat <= ~s;
  endtask : send_tx

  task send_rx(input logic [16:0] s);
    @(posedge i_ref_clk);
    o_rx_done <= 1'b1;
    o_rx_stat <= s;
    @(posedge i_ref_clk);
    o_rx_done <= 1'b0;
    o_rx_stat <= ~s;
  endtask : send_rx
endmodule : msc_frame_src

// *** bench/msc_stat_counters_test.sv ***
module msc_stat_counters_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] rdata;
  logic tx_done;
  logic rx_done;
  logic [9:0] tx_stat;
  logic [16:0] rx_stat;
  logic [31:0] exp_cnt [12] = '{default: 32'h0};
  int fail_count = 0;
  int n_compared = 0;

  always #20 clk = ~clk;

  msc_frame_src src (.i_ref_clk(clk), .o_tx_done(tx_done), .o_tx_stat(tx_stat),
    .o_rx_done(rx_done), .o_rx_stat(rx_stat));

  msc_stat_counters dut (.i_ref_clk(clk), .i_nrst(nrst), .i_clk_en(clk_en),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_tx_done(tx_done), .i_tx_underrun(tx_stat[9]), .i_tx_coll_cnt(tx_stat[8:4]),
    .i_tx_late_coll(tx_stat[3]), .i_tx_deferred(tx_stat[2]),
    .i_tx_crs_seen(tx_stat[1]), .i_tx_crs_dropped(tx_stat[0]),
    .i_rx_done(rx_done), .i_rx_len(rx_stat[16:6]), .i_rx_odd_bits(rx_stat[5]),
    .i_rx_crc_bad(rx_stat[4]), .i_rx_sym_err(rx_stat[3]),
    .i_rx_addr_match(rx_stat[2]), .i_rx_copied(rx_stat[1]), .i_rx_pause(rx_stat[0]));

  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task reg_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // Reads every counter, which also clears it
  task check_all(input string tname);
    logic [31:0] v;
    for (int i = 0; i < 12; i++) begin
      reg_rd(msc_pkg::CNT_ADDR[i], v);
      check($sformatf("%s counter %0d", tname, i), exp_cnt[i], v);
      exp_cnt[i] = 32'h0;
    end
    $display("test %s finished", tname);
  endtask : check_all

  // Mask bit i means counter i advances by one
  task bump(input logic [11:0] m);
    for (int i = 0; i < 12; i++) begin
      if (m[i]) begin
        exp_cnt[i] = exp_cnt[i] + 32'h1;
      end
    end
  endtask : bump

  // Status {underrun, collisions, late, deferred, carrier seen, carrier dropped}
  task tx(input logic [9:0] s, input logic [11:0] m);
    src.send_tx(s);
    bump(m);
  endtask : tx

  // Status {length, odd bits, crc bad, symbol error, match, copied, pause}
  task rx(input logic [10:0] len, input logic [5:0] f, input logic [11:0] m);
    src.send_rx({len, f});
    bump(m);
  endtask : rx

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [31:0] v;
    reg_rd(32'hf802c06c, v);
    check("unmapped read", 32'h0, v);
    check_all("reset");
  endtask : t_reset

  task t_collisions;
    tx({1'b0, 5'h01, 4'h2}, 12'h006);
    tx({1'b0, 5'h02, 4'h2}, 12'h00a);
    tx({1'b0, 5'h0f, 4'ha}, 12'h10a);
    tx({1'b0, 5'h10, 4'h2}, 12'h200);
    check_all("collisions");
  endtask : t_collisions

  task t_underrun_defer;
    tx({1'b1, 5'h01, 4'h4}, 12'h400);
    tx({1'b1, 5'h00, 4'h0}, 12'h400);
    tx({1'b0, 5'h00, 4'h6}, 12'h082);
    tx({1'b0, 5'h01, 4'h6}, 12'h006);
    check_all("underrun_defer");
  endtask : t_underrun_defer

  task t_carrier;
    tx({1'b0, 5'h00, 4'h0}, 12'h802);
    tx({1'b0, 5'h00, 4'h3}, 12'h802);
    tx({1'b0, 5'h01, 4'h0}, 12'h006);
    reg_wr(msc_pkg::NET_CONFIG_ADDR, 32'h2);
    tx({1'b0, 5'h00, 4'h0}, 12'h002);
    reg_wr(msc_pkg::NET_CONFIG_ADDR, 32'h0);
    check_all("carrier");
  endtask : t_carrier

  task t_receive;
    rx(11'h040, 6'h07, 12'h000);
    reg_wr(msc_pkg::NET_CONTROL_ADDR, 32'h4);
    rx(11'h040, 6'h07, 12'h011);
    rx(11'h5ee, 6'h06, 12'h010);
    rx(11'h03f, 6'h06, 12'h000);
    rx(11'h5ef, 6'h06, 12'h000);
    rx(11'h040, 6'h04, 12'h000);
    rx(11'h040, 6'h16, 12'h020);
    rx(11'h5ef, 6'h16, 12'h000);
    rx(11'h5ee, 6'h36, 12'h040);
    rx(11'h040, 6'h0e, 12'h020);
    rx(11'h040, 6'h2e, 12'h040);
    reg_wr(msc_pkg::NET_CONFIG_ADDR, 32'h100);
    rx(11'h600, 6'h07, 12'h011);
    rx(11'h601, 6'h07, 12'h000);
    reg_wr(msc_pkg::NET_CONFIG_ADDR, 32'h0);
    check_all("receive");
  endtask : t_receive

  task t_saturate;
    logic [31:0] v;
    reg_wr(msc_pkg::CRC_ERROR_ADDR, 32'hfe);
    reg_rd(msc_pkg::CRC_ERROR_ADDR, v);
    check("locked write", 32'h0, v);
    reg_wr(msc_pkg::NET_CONTROL_ADDR, 32'h84);
    reg_wr(msc_pkg::CRC_ERROR_ADDR, 32'hfe);
    rx(11'h040, 6'h16, 12'h000);
    rx(11'h040, 6'h16, 12'h000);
    exp_cnt[msc_pkg::IDX_CRC] = 32'hff;
    check_all("saturate");
    reg_wr(msc_pkg::NET_CONTROL_ADDR, 32'h0);
  endtask : t_saturate

  // A sent frame while frozen must leave every counter alone
  task t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    tx({1'b0, 5'h00, 4'h2}, 12'h000);
    @(posedge clk);
    clk_en <= 1'b1;
    check_all("freeze");
  endtask : t_freeze

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_collisions();
    t_underrun_defer();
    t_carrier();
    t_receive();
    t_saturate();
    t_freeze();
    give_verdict();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : msc_stat_counters_test
